// ### usr_sched_regs.v
`timescale 1ns/100ps
`include "usr_defines.vh"

module usr_sched_regs #(
    parameter TICK_CYCLES = `USR_TICK_CYCLES,
    parameter AW          = 16,
    parameter NBANK       = 4
) (
    // clock and reset
    input  wire          clk_sys_i,
    input  wire          nrst_i,
    input  wire          ctrl_reset_i,
    // register port
    input  wire [11:0]   reg_addr_i,
    input  wire          reg_wr_i,
    input  wire          reg_rd_i,
    input  wire [31:0]   reg_wdata_i,
    output reg  [31:0]   reg_rdata_o,
    // memory access
    input  wire          pio_mem_rd_i,
    input  wire          dma_active_i,
    output wire [AW-1:0] mem_rd_addr_o,
    output wire [1:0]    mem_bank_o,
    // scheduler
    input  wire          sched_start_i,
    input  wire          desc_valid_i,
    input  wire          desc_skip_i,
    output wire          walk_async_o,
    output wire          walk_periodic_o,
    output wire          walk_iso_o,
    output wire          desc_process_o,
    input  wire          async_done_i,
    input  wire          timeout_irq_en_i,
    output reg           timeout_irq_o
);

    localparam TCW = 32;

    reg  [`USR_PENDING_W-1:0] pending_q;
    reg  [31:0]               timeout_q;
    reg  [1:0]                bank_q;
    reg  [TCW-1:0]            tick_cnt_q;
    reg  [31:0]               ms_cnt_q;
    reg                       armed_q;
    wire                      tick;
    wire                      wr_pend;
    wire                      wr_tmo;
    wire                      wr_mem;
    wire [AW-1:0]             ptr [0:NBANK-1];
    wire                      inc_bank;
    reg  [`USR_PENDING_W-1:0] pending_d;
    reg  [31:0]               timeout_d;
    reg  [1:0]                bank_d;
    reg  [TCW-1:0]            tick_cnt_d;
    reg  [31:0]               ms_cnt_d;
    reg                       armed_d;
    reg                       irq_d;
    reg  [AW-1:0]             rd_addr_q;
    reg  [AW-1:0]             rd_addr_d;
    reg  [31:0]               rdata_d;

    assign wr_pend = reg_wr_i && (reg_addr_i == `USR_OFS_PENDING);
    assign wr_tmo  = reg_wr_i && (reg_addr_i == `USR_OFS_TIMEOUT);
    assign wr_mem  = reg_wr_i && (reg_addr_i == `USR_OFS_MEMPTR);
    // dma traffic never moves the bank pointers
    assign inc_bank = (pio_mem_rd_i && !dma_active_i);

    // register write decode
    always @* begin
        pending_d = pending_q;
        timeout_d = timeout_q;
        bank_d    = bank_q;
        if (wr_pend) begin
            pending_d = reg_wdata_i[`USR_PENDING_W-1:0];
        end
        if (wr_tmo) begin
            timeout_d = reg_wdata_i;
        end
        if (wr_mem) begin
            bank_d = reg_wdata_i[`USR_BANK_MSB:`USR_BANK_LSB];
        end
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pending_q <= `USR_RST_PENDING;
            timeout_q <= `USR_RST_TIMEOUT;
            bank_q    <= 2'h0;
        end else if (ctrl_reset_i) begin
            pending_q <= `USR_RST_PENDING;
            timeout_q <= `USR_RST_TIMEOUT;
            bank_q    <= 2'h0;
        end else begin
            pending_q <= pending_d;
            timeout_q <= timeout_d;
            bank_q    <= bank_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBANK; g = g + 1) begin : g_bank
            usr_bank_ptr #(
                .AW (AW)
            ) u_ptr (
                .clk_sys_i (clk_sys_i),
                .nrst_i    (nrst_i),
                .srst_i    (ctrl_reset_i),
                .load_i    (wr_mem && (reg_wdata_i[`USR_BANK_MSB:`USR_BANK_LSB] == g)),
                .addr_i    (reg_wdata_i[`USR_ADDR_MSB:0]),
                .inc_i     (inc_bank && !wr_mem && (bank_q == g)),
                .ptr_o     (ptr[g])
            );
        end
    endgenerate

    // flop copy of the selected bank pointer keeps the address output registered
    always @* begin
        rd_addr_d = rd_addr_q;
        if (ctrl_reset_i) begin
            rd_addr_d = {AW{1'b0}};
        end else if (wr_mem) begin
            rd_addr_d = reg_wdata_i[AW-1:0];
        end else if (inc_bank) begin
            rd_addr_d = rd_addr_q + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_addr_q <= {AW{1'b0}};
        end else begin
            rd_addr_q <= rd_addr_d;
        end
    end

    assign mem_rd_addr_o = rd_addr_q;
    assign mem_bank_o    = bank_q;

    // scheduler area gating
    assign walk_async_o    = sched_start_i && pending_q[`USR_BIT_ASYNC];
    assign walk_periodic_o = sched_start_i && pending_q[`USR_BIT_PERIODIC];
    assign walk_iso_o      = sched_start_i && pending_q[`USR_BIT_ISO];
    assign desc_process_o  = (walk_async_o || walk_periodic_o || walk_iso_o)
                             && desc_valid_i && !desc_skip_i;

    // millisecond tick
    assign tick = (tick_cnt_q == TICK_CYCLES - 1);

    always @* begin
        if (tick || ctrl_reset_i) begin
            tick_cnt_d = {TCW{1'b0}};
        end else begin
            tick_cnt_d = tick_cnt_q + 32'h00000001;
        end
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_q <= {TCW{1'b0}};
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // timeout armed by completed async descriptors only
    always @* begin
        armed_d  = armed_q;
        ms_cnt_d = ms_cnt_q;
        irq_d    = 1'b0;
        if (ctrl_reset_i || wr_tmo) begin
            armed_d  = 1'b0;
            ms_cnt_d = 32'h00000000;
        end else if (async_done_i && (timeout_q != 32'h00000000)) begin
            armed_d  = 1'b1;
            ms_cnt_d = 32'h00000000;
        end else if (armed_q && tick) begin
            if (ms_cnt_q + 32'h00000001 >= timeout_q) begin
                armed_d  = 1'b0;
                ms_cnt_d = 32'h00000000;
                irq_d    = timeout_irq_en_i;
            end else begin
                ms_cnt_d = ms_cnt_q + 32'h00000001;
            end
        end
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed_q       <= 1'b0;
            ms_cnt_q      <= 32'h00000000;
            timeout_irq_o <= 1'b0;
        end else begin
            armed_q       <= armed_d;
            ms_cnt_q      <= ms_cnt_d;
            timeout_irq_o <= irq_d;
        end
    end

    // read data
    always @* begin
        case (reg_addr_i)
            `USR_OFS_PENDING: rdata_d = {29'h0, pending_q};
            `USR_OFS_TIMEOUT: rdata_d = timeout_q;
            `USR_OFS_MEMPTR:  rdata_d = {14'h0, bank_q, ptr[bank_q]};
            default:          rdata_d = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end
    end

endmodule

// ### usr_defines.vh
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH

// register byte offsets
`define USR_OFS_PENDING      12'h334
`define USR_OFS_TIMEOUT      12'h338
`define USR_OFS_MEMPTR       12'h33c
`define USR_OFS_HC_LIMIT     12'h300

// list pending flag positions
`define USR_BIT_ASYNC        0
`define USR_BIT_PERIODIC     1
`define USR_BIT_ISO          2
`define USR_PENDING_W        3

// memory register fields
`define USR_ADDR_MSB         15
`define USR_BANK_LSB         16
`define USR_BANK_MSB         17

// reset values
`define USR_RST_PENDING      3'h0
`define USR_RST_TIMEOUT      32'h00000000
`define USR_RST_ADDR         16'h0000

// timing
`define USR_CLK_HZ           10000000
`define USR_TICK_MS          1
`define USR_TICK_CYCLES      ((`USR_CLK_HZ / 1000) * `USR_TICK_MS)

`endif

// ### usr_bank_ptr.v
`timescale 1ns/100ps
`include "usr_defines.vh"

module usr_bank_ptr #(
    parameter AW = 16
) (
    // clock and reset
    input  wire          clk_sys_i,
    input  wire          nrst_i,
    input  wire          srst_i,
    // control
    input  wire          load_i,
    input  wire [AW-1:0] addr_i,
    input  wire          inc_i,
    // state
    output reg  [AW-1:0] ptr_o
);

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_o <= {AW{1'b0}};
        end else if (srst_i) begin
            ptr_o <= {AW{1'b0}};
        end else if (load_i) begin
            ptr_o <= addr_i;
        end else if (inc_i) begin
            ptr_o <= ptr_o + {{(AW-1){1'b0}}, 1'b1};
        end
    end

endmodule

// ### usr_sched_regs_assertions.sv
`timescale 1ns/100ps
module usr_sched_regs_assertions #(parameter AW = 16) (
    input wire logic clk_sys_i, nrst_i, ctrl_reset_i, reg_wr_i, pio_mem_rd_i, dma_active_i,
    input wire logic sched_start_i, desc_valid_i, desc_skip_i, walk_async_o, walk_periodic_o,
    input wire logic walk_iso_o, desc_process_o, timeout_irq_o, timeout_irq_en_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [AW-1:0] mem_rd_addr_o,
    input wire logic [1:0] mem_bank_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    wire wp = reg_wr_i && reg_addr_i == 12'h334 && !ctrl_reset_i;
    wire wm = reg_wr_i && reg_addr_i == 12'h33c && !ctrl_reset_i;
    wire [2:0] walk = {walk_iso_o, walk_periodic_o, walk_async_o};
    a_desc_gate: assert property (
        desc_process_o == (|walk && desc_valid_i && !desc_skip_i)) else $error("bad gate");
    a_walk_flags: assert property (
        wp ##1 sched_start_i |-> walk == $past(reg_wdata_i[2:0])) else $error("bad walk");
    a_walk_idle: assert property (
        !sched_start_i |-> walk == 3'h0) else $error("walk without start");
    a_mem_load: assert property (
        wm |=> {mem_bank_o, mem_rd_addr_o} == $past(reg_wdata_i[17:0])) else $error("bad load");
    a_mem_inc: assert property (
        pio_mem_rd_i && !dma_active_i && !wm && !ctrl_reset_i
        |=> mem_rd_addr_o == $past(mem_rd_addr_o) + 1'b1) else $error("no increment");
    a_dma_hold: assert property (
        (dma_active_i || !pio_mem_rd_i) && !wm && !ctrl_reset_i
        |=> $stable({mem_bank_o, mem_rd_addr_o})) else $error("pointer moved");
    a_ctrl_reset: assert property (
        ctrl_reset_i |=> {mem_bank_o, mem_rd_addr_o, timeout_irq_o, walk} == 0)
        else $error("reset incomplete");
    a_irq_pulse: assert property (
        timeout_irq_o |=> !timeout_irq_o) else $error("irq too long");
    a_irq_enable: assert property (
        timeout_irq_o |-> $past(timeout_irq_en_i)) else $error("irq while disabled");
endmodule
bind usr_sched_regs usr_sched_regs_assertions #(
    .AW (AW)
) i_chk (
    .clk_sys_i        (clk_sys_i),
    .nrst_i           (nrst_i),
    .ctrl_reset_i     (ctrl_reset_i),
    .reg_wr_i         (reg_wr_i),
    .pio_mem_rd_i     (pio_mem_rd_i),
    .dma_active_i     (dma_active_i),
    .sched_start_i    (sched_start_i),
    .desc_valid_i     (desc_valid_i),
    .desc_skip_i      (desc_skip_i),
    .walk_async_o     (walk_async_o),
    .walk_periodic_o  (walk_periodic_o),
    .walk_iso_o       (walk_iso_o),
    .desc_process_o   (desc_process_o),
    .timeout_irq_o    (timeout_irq_o),
    .timeout_irq_en_i (timeout_irq_en_i),
    .reg_addr_i       (reg_addr_i),
    .reg_wdata_i      (reg_wdata_i),
    .mem_rd_addr_o    (mem_rd_addr_o),
    .mem_bank_o       (mem_bank_o)
);

// ### usr_cpu_model.sv
`timescale 1ns/100ps
module usr_cpu_model (
    input  wire        clk_sys_i,
    output reg  [11:0] reg_addr_i = 0,
    output reg         reg_wr_i = 0,
    output reg         reg_rd_i = 0,
    output reg  [31:0] reg_wdata_i = 0,
    input  wire [31:0] reg_rdata_o
);
    // released lines carry inverted leftovers
    task wr(input [11:0] a, input [31:0] d);
        @(posedge clk_sys_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_sys_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {~a, ~d, 1'b0};
    endtask
    task rd(input [11:0] a, output [31:0] d);
        @(posedge clk_sys_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_sys_i);
        {reg_addr_i, reg_rd_i} <= {~a, 1'b0};
        @(negedge clk_sys_i);
        d = reg_rdata_o;
    endtask
endmodule

// ### usr_sched_regs_test.sv
`timescale 1ns/100ps
module usr_sched_regs_test;
    localparam T = 10;
    reg  clk_sys_i = 0, nrst_i = 0, ctrl_reset_i = 0, pio_mem_rd_i = 0, dma_active_i = 0;
    reg  sched_start_i = 0, desc_valid_i = 0, desc_skip_i = 0, async_done_i = 0;
    reg  timeout_irq_en_i = 0;
    wire [11:0] reg_addr_i;
    wire reg_wr_i, reg_rd_i, walk_async_o, walk_periodic_o, walk_iso_o;
    wire desc_process_o, timeout_irq_o;
    wire [31:0] reg_wdata_i, reg_rdata_o;
    wire [15:0] mem_rd_addr_o;
    wire [1:0] mem_bank_o;
    integer err_count = 0, checked = 0, i, k, pend, ptr, c;
    reg [31:0] d, e;
    always #50 clk_sys_i = ~clk_sys_i;
    usr_sched_regs #(
        .TICK_CYCLES (T)
    ) i_dut (
        .clk_sys_i        (clk_sys_i),
        .nrst_i           (nrst_i),
        .ctrl_reset_i     (ctrl_reset_i),
        .reg_addr_i       (reg_addr_i),
        .reg_wr_i         (reg_wr_i),
        .reg_rd_i         (reg_rd_i),
        .reg_wdata_i      (reg_wdata_i),
        .reg_rdata_o      (reg_rdata_o),
        .pio_mem_rd_i     (pio_mem_rd_i),
        .dma_active_i     (dma_active_i),
        .mem_rd_addr_o    (mem_rd_addr_o),
        .mem_bank_o       (mem_bank_o),
        .sched_start_i    (sched_start_i),
        .desc_valid_i     (desc_valid_i),
        .desc_skip_i      (desc_skip_i),
        .walk_async_o     (walk_async_o),
        .walk_periodic_o  (walk_periodic_o),
        .walk_iso_o       (walk_iso_o),
        .desc_process_o   (desc_process_o),
        .async_done_i     (async_done_i),
        .timeout_irq_en_i (timeout_irq_en_i),
        .timeout_irq_o    (timeout_irq_o)
    );
    usr_cpu_model i_cpu (
        .clk_sys_i   (clk_sys_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_rdata_o (reg_rdata_o)
    );
    task chk(input [31:0] got, input [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task zeros;
        for (i = 0; i < 4; i = i + 1) begin
            i_cpu.rd(12'h334 + 4 * i, d);
            chk(d, 0);
        end
    endtask
    initial begin
        d = $urandom(32'hddf7);
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1;
        zeros;
        for (i = 0; i < 16; i = i + 1) begin
            pend = i % 8;
            @(posedge clk_sys_i);
            {sched_start_i, desc_valid_i, desc_skip_i} <= $urandom;
            i_cpu.wr(12'h334, pend);
            @(negedge clk_sys_i);
            chk({walk_iso_o, walk_periodic_o, walk_async_o}, sched_start_i ? pend : 0);
            chk(desc_process_o, sched_start_i && pend && desc_valid_i && !desc_skip_i);
        end
        i_cpu.rd(12'h334, d);
        chk(d, pend);
        d = $urandom;
        i_cpu.wr(12'h338, d);
        i_cpu.rd(12'h338, e);
        chk(e, d);
        // arm two ms without and with the enable, then a zero timeout
        for (k = 0; k < 3; k = k + 1) begin
            i_cpu.wr(12'h338, (k == 2) ? 0 : 2);
            @(posedge clk_sys_i);
            {timeout_irq_en_i, async_done_i} <= {k != 0, 1'b1};
            @(posedge clk_sys_i);
            async_done_i <= 0;
            c = 0;
            while (!timeout_irq_o && c < 40) begin
                @(negedge clk_sys_i);
                c = c + 1;
            end
            chk(c > T && c <= 2 * T + 2, k == 1);
        end
        for (k = 0; k < 4; k = k + 1) begin
            ptr = (k == 3) ? 16'hfffe : $urandom % 65536;
            @(posedge clk_sys_i);
            pio_mem_rd_i <= 0;
            i_cpu.wr(12'h33c, {14'h0, k[1:0], ptr[15:0]});
            for (i = 0; i < 6; i = i + 1) begin
                @(posedge clk_sys_i);
                {pio_mem_rd_i, dma_active_i} <= $urandom;
                @(negedge clk_sys_i);
                chk({mem_bank_o, mem_rd_addr_o}, {k[1:0], ptr[15:0]});
                if (pio_mem_rd_i && !dma_active_i)
                    ptr = (ptr + 1) % 65536;
            end
        end
        @(posedge clk_sys_i);
        {ctrl_reset_i, pio_mem_rd_i} <= 2'b10;
        @(posedge clk_sys_i);
        ctrl_reset_i <= 0;
        @(negedge clk_sys_i);
        chk({mem_bank_o, mem_rd_addr_o}, 0);
        zeros;
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        err_count = err_count + 1;
        end_sim;
    end
endmodule
